// [verilog/intc_pkg.sv]
package intc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_EN_UPPER = 8'h00;
  localparam logic [7:0] OFS_PRIO_FIRST = 8'h04;
  localparam logic [7:0] OFS_CORE_EN = 8'h08;
  localparam logic [7:0] OFS_PENDING = 8'h0c;
  localparam logic [7:0] OFS_GRANT = 8'h10;
  localparam logic [31:0] RST_EN_UPPER = 32'h00000000;
  localparam logic [31:0] RST_PRIO_FIRST = 32'h00000000;
  localparam logic [3:0] RST_CORE_EN = 4'h0;
  localparam logic [31:0] MASK_EN_UPPER = 32'h00003fff;
  localparam logic [31:0] MASK_PRIO_FIRST = 32'h1f1f1f1f;
  localparam logic [31:0] MASK_CORE_EN = 32'h0000000f;
  localparam int BIT_TW2_MASTER = 13;
  localparam int BIT_TW2_SLAVE = 12;
  localparam int BIT_TW2_COLLISION = 11;
  localparam int BIT_SER2_TX = 10;
  localparam int BIT_SER2_RX = 9;
  localparam int BIT_SER2_ERR = 8;
  localparam int BIT_SYNC2_RX = 7;
  localparam int BIT_SYNC2_TX = 6;
  localparam int BIT_SYNC2_ERR = 5;
  localparam int BIT_CMP_B = 4;
  localparam int BIT_CMP_A = 3;
  localparam int BIT_PARALLEL = 2;
  localparam int BIT_CONVERTER = 1;
  localparam int BIT_INPUT_CHANGE = 0;
  localparam int N_UPPER = 14;
  localparam int N_CORE = 4;
  // core source index i owns byte i of the priority register
  localparam int FIELD_STRIDE = 8;
  localparam int SUB_LSB = 0;
  localparam int PRIO_LSB = 2;
  localparam int IDX_CORE_TIMER = 0;
  localparam int IDX_SOFT0 = 1;
  localparam int IDX_SOFT1 = 2;
  localparam int IDX_EXT0 = 3;
  localparam int GRANT_VALID_BIT = 8;
  localparam int GRANT_ID_LSB = 5;
  localparam int PEND_CORE_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic addr_hit(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    addr_hit = (a == OFS_EN_UPPER) || (a == OFS_PRIO_FIRST) || (a == OFS_CORE_EN)
      || (a == OFS_PENDING) || (a == OFS_GRANT);
  endfunction : addr_hit

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_strb = ((old_v & ~m) | (new_v & m)) & mask;
  endfunction : merge_strb
endpackage : intc_pkg

// [verilog/intc_ifs.sv]
`timescale 1ns/1ps
interface intc_regbus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport bus_side (output wr_en, output wr_addr, output wr_data, output wr_strb,
    output rd_addr, input rd_data);
  modport reg_side (input wr_en, input wr_addr, input wr_data, input wr_strb,
    input rd_addr, output rd_data);
endinterface : intc_regbus_if

interface intc_arb_if;
  logic [3:0] elig;
  logic [31:0] prio;
  logic grant_valid;
  logic [1:0] grant_id;
  logic [2:0] grant_prio;
  logic [1:0] grant_sub;
  modport req_side (output elig, output prio, input grant_valid, input grant_id,
    input grant_prio, input grant_sub);
  modport arb_side (input elig, input prio, output grant_valid, output grant_id,
    output grant_prio, output grant_sub);
endinterface : intc_arb_if

// [verilog/intc_axil_slave.sv]
`timescale 1ns/1ps
module intc_axil_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  intc_regbus_if.bus_side bus
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } intc_axil_st_t;

  intc_axil_st_t st_r;
  intc_axil_st_t st_nxt;
  logic do_write;

  // address and data may come in either order; the response waits for both
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign bus.wr_en = do_write && intc_pkg::addr_hit(st_r.awaddr);
  assign bus.wr_addr = {st_r.awaddr[7:2], 2'b00};
  assign bus.wr_data = st_r.wdata;
  assign bus.wr_strb = st_r.wstrb;
  assign bus.rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  always_comb begin
    st_nxt = st_r;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = intc_pkg::addr_hit(st_r.awaddr) ? intc_pkg::RESP_OKAY
        : intc_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = intc_pkg::addr_hit(s_axi_araddr) ? bus.rd_data : 32'h00000000;
      st_nxt.rresp = intc_pkg::addr_hit(s_axi_araddr) ? intc_pkg::RESP_OKAY
        : intc_pkg::RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : intc_axil_slave

// [verilog/intc_arbiter.sv]
`timescale 1ns/1ps
module intc_arbiter (
  input wire logic clk,
  input wire logic sys_rst,
  intc_arb_if.arb_side arb
);
  typedef struct packed {
    logic valid;
    logic [1:0] id;
    logic [2:0] prio;
    logic [1:0] sub;
  } intc_arb_st_t;

  intc_arb_st_t st_r;
  intc_arb_st_t st_nxt;
  logic [2:0] p [intc_pkg::N_CORE];
  logic [1:0] s [intc_pkg::N_CORE];

  genvar g;
  generate
    for (g = 0; g < intc_pkg::N_CORE; g++) begin : g_field
      assign p[g] = arb.prio[g*intc_pkg::FIELD_STRIDE+intc_pkg::PRIO_LSB +: 3];
      assign s[g] = arb.prio[g*intc_pkg::FIELD_STRIDE+intc_pkg::SUB_LSB +: 2];
    end
  endgenerate

  // higher priority wins, then higher subpriority, then the lower index
  always_comb begin
    st_nxt = '0;
    for (int i = 0; i < intc_pkg::N_CORE; i++) begin
      if (arb.elig[i] && (!st_nxt.valid || p[i] > st_nxt.prio
          || (p[i] == st_nxt.prio && s[i] > st_nxt.sub))) begin
        st_nxt.valid = 1'b1;
        st_nxt.id = 2'(i);
        st_nxt.prio = p[i];
        st_nxt.sub = s[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign arb.grant_valid = st_r.valid;
  assign arb.grant_id = st_r.id;
  assign arb.grant_prio = st_r.prio;
  assign arb.grant_sub = st_r.sub;
endmodule : intc_arbiter

// [verilog/intc_top.sv]
`timescale 1ns/1ps
module intc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [13:0] upper_flag,
  input wire logic [13:0] upper_prio_nz,
  output logic [13:0] upper_req,
  input wire logic [3:0] core_flag,
  output logic core_grant_valid,
  output logic [1:0] core_grant_id,
  output logic [2:0] core_grant_prio,
  output logic [1:0] core_grant_sub
);
  typedef struct packed {
    logic [31:0] en_upper;
    logic [31:0] prio_first;
    logic [3:0] core_en;
    logic [13:0] upper_req;
  } intc_top_st_t;

  intc_top_st_t st_r;
  intc_top_st_t st_nxt;
  logic [3:0] core_elig;
  logic [2:0] core_prio [intc_pkg::N_CORE];
  logic [13:0] upper_en;
  logic [13:0] upper_gate;
  logic [31:0] pending_word;
  logic [31:0] grant_word;
  logic twowire2_master_irq_en;
  logic twowire2_slave_irq_en;
  logic twowire2_collision_irq_en;
  logic serial2_tx_irq_en;
  logic serial2_rx_irq_en;
  logic serial2_err_irq_en;
  logic sync2_rx_irq_en;
  logic sync2_tx_irq_en;
  logic sync2_err_irq_en;
  logic comparator_b_irq_en;
  logic comparator_a_irq_en;
  logic parallel_port_irq_en;
  logic converter_irq_en;
  logic input_change_irq_en;
  logic [2:0] ext_irq0_priority;
  logic [1:0] ext_irq0_subpriority;
  logic [2:0] soft_irq1_priority;
  logic [1:0] soft_irq1_subpriority;
  logic [2:0] soft_irq0_priority;
  logic [1:0] soft_irq0_subpriority;
  logic [2:0] core_timer_priority;
  logic [1:0] core_timer_subpriority;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_EN_UPPER,
    SEL_PRIO_FIRST,
    SEL_CORE_EN,
    SEL_PENDING,
    SEL_GRANT
  } intc_reg_sel_t;

  intc_reg_sel_t wr_sel;
  intc_reg_sel_t rd_sel;

  // one decoder serves writes and reads so the two maps cannot drift apart
  function automatic intc_reg_sel_t reg_sel(input logic [7:0] addr);
    case (addr)
      intc_pkg::OFS_EN_UPPER: begin
        reg_sel = SEL_EN_UPPER;
      end
      intc_pkg::OFS_PRIO_FIRST: begin
        reg_sel = SEL_PRIO_FIRST;
      end
      intc_pkg::OFS_CORE_EN: begin
        reg_sel = SEL_CORE_EN;
      end
      intc_pkg::OFS_PENDING: begin
        reg_sel = SEL_PENDING;
      end
      intc_pkg::OFS_GRANT: begin
        reg_sel = SEL_GRANT;
      end
      default: begin
        reg_sel = SEL_NONE;
      end
    endcase
  endfunction : reg_sel

  // field pickers for the named views; prio_of also serves the per-source loop
  function automatic logic [2:0] prio_of(input logic [31:0] r, input int idx);
    prio_of = r[idx*intc_pkg::FIELD_STRIDE+intc_pkg::PRIO_LSB +: 3];
  endfunction : prio_of

  function automatic logic [1:0] sub_of(input logic [31:0] r, input int idx);
    sub_of = r[idx*intc_pkg::FIELD_STRIDE+intc_pkg::SUB_LSB +: 2];
  endfunction : sub_of

  intc_regbus_if bus ();
  intc_arb_if arb ();

  intc_axil_slave u_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus(bus.bus_side)
  );

  intc_arbiter u_arb (
    .clk(clk),
    .sys_rst(sys_rst),
    .arb(arb.arb_side)
  );

  assign twowire2_master_irq_en = st_r.en_upper[intc_pkg::BIT_TW2_MASTER];
  assign twowire2_slave_irq_en = st_r.en_upper[intc_pkg::BIT_TW2_SLAVE];
  assign twowire2_collision_irq_en = st_r.en_upper[intc_pkg::BIT_TW2_COLLISION];
  assign serial2_tx_irq_en = st_r.en_upper[intc_pkg::BIT_SER2_TX];
  assign serial2_rx_irq_en = st_r.en_upper[intc_pkg::BIT_SER2_RX];
  assign serial2_err_irq_en = st_r.en_upper[intc_pkg::BIT_SER2_ERR];
  assign sync2_rx_irq_en = st_r.en_upper[intc_pkg::BIT_SYNC2_RX];
  assign sync2_tx_irq_en = st_r.en_upper[intc_pkg::BIT_SYNC2_TX];
  assign sync2_err_irq_en = st_r.en_upper[intc_pkg::BIT_SYNC2_ERR];
  assign comparator_b_irq_en = st_r.en_upper[intc_pkg::BIT_CMP_B];
  assign comparator_a_irq_en = st_r.en_upper[intc_pkg::BIT_CMP_A];
  assign parallel_port_irq_en = st_r.en_upper[intc_pkg::BIT_PARALLEL];
  assign converter_irq_en = st_r.en_upper[intc_pkg::BIT_CONVERTER];
  assign input_change_irq_en = st_r.en_upper[intc_pkg::BIT_INPUT_CHANGE];

  // rebuilt from the named bits so nothing above bit 13 reaches a request
  always_comb begin
    upper_en = 14'h0000;
    upper_en[intc_pkg::BIT_TW2_MASTER] = twowire2_master_irq_en;
    upper_en[intc_pkg::BIT_TW2_SLAVE] = twowire2_slave_irq_en;
    upper_en[intc_pkg::BIT_TW2_COLLISION] = twowire2_collision_irq_en;
    upper_en[intc_pkg::BIT_SER2_TX] = serial2_tx_irq_en;
    upper_en[intc_pkg::BIT_SER2_RX] = serial2_rx_irq_en;
    upper_en[intc_pkg::BIT_SER2_ERR] = serial2_err_irq_en;
    upper_en[intc_pkg::BIT_SYNC2_RX] = sync2_rx_irq_en;
    upper_en[intc_pkg::BIT_SYNC2_TX] = sync2_tx_irq_en;
    upper_en[intc_pkg::BIT_SYNC2_ERR] = sync2_err_irq_en;
    upper_en[intc_pkg::BIT_CMP_B] = comparator_b_irq_en;
    upper_en[intc_pkg::BIT_CMP_A] = comparator_a_irq_en;
    upper_en[intc_pkg::BIT_PARALLEL] = parallel_port_irq_en;
    upper_en[intc_pkg::BIT_CONVERTER] = converter_irq_en;
    upper_en[intc_pkg::BIT_INPUT_CHANGE] = input_change_irq_en;
  end

  assign ext_irq0_priority = prio_of(st_r.prio_first, intc_pkg::IDX_EXT0);
  assign ext_irq0_subpriority = sub_of(st_r.prio_first, intc_pkg::IDX_EXT0);
  assign soft_irq1_priority = prio_of(st_r.prio_first, intc_pkg::IDX_SOFT1);
  assign soft_irq1_subpriority = sub_of(st_r.prio_first, intc_pkg::IDX_SOFT1);
  assign soft_irq0_priority = prio_of(st_r.prio_first, intc_pkg::IDX_SOFT0);
  assign soft_irq0_subpriority = sub_of(st_r.prio_first, intc_pkg::IDX_SOFT0);
  assign core_timer_priority = prio_of(st_r.prio_first, intc_pkg::IDX_CORE_TIMER);
  assign core_timer_subpriority = sub_of(st_r.prio_first, intc_pkg::IDX_CORE_TIMER);

  assign wr_sel = reg_sel(bus.wr_addr);
  assign rd_sel = reg_sel(bus.rd_addr);

  // priority fields per byte: core timer, soft 0, soft 1, ext 0 upward
  genvar g;
  generate
    for (g = 0; g < intc_pkg::N_CORE; g++) begin : g_core
      assign core_prio[g] = prio_of(st_r.prio_first, g);
      // a zero priority field kills the source even when enabled
      assign core_elig[g] = core_flag[g] && st_r.core_en[g]
        && (core_prio[g] != 3'h0);
    end
  endgenerate

  // one gate per upper source: flag, enable and nonzero priority together
  generate
    for (g = 0; g < intc_pkg::N_UPPER; g++) begin : g_upper
      assign upper_gate[g] = upper_flag[g] && upper_en[g] && upper_prio_nz[g];
    end
  endgenerate

  assign arb.elig = core_elig;
  // reserved bits reach the arbiter as zero whatever the register holds
  assign arb.prio = {
    3'h0, ext_irq0_priority, ext_irq0_subpriority,
    3'h0, soft_irq1_priority, soft_irq1_subpriority,
    3'h0, soft_irq0_priority, soft_irq0_subpriority,
    3'h0, core_timer_priority, core_timer_subpriority
  };

  // register writes; masks keep reserved bits at zero whatever software sends
  always_comb begin
    st_nxt = st_r;
    if (bus.wr_en) begin
      case (wr_sel)
        SEL_EN_UPPER: begin
          st_nxt.en_upper = intc_pkg::merge_strb(st_r.en_upper, bus.wr_data,
            bus.wr_strb, intc_pkg::MASK_EN_UPPER);
        end
        SEL_PRIO_FIRST: begin
          st_nxt.prio_first = intc_pkg::merge_strb(st_r.prio_first, bus.wr_data,
            bus.wr_strb, intc_pkg::MASK_PRIO_FIRST);
        end
        SEL_CORE_EN: begin
          if (bus.wr_strb[0]) begin
            st_nxt.core_en = bus.wr_data[3:0];
          end
        end
        default: begin
          st_nxt.core_en = st_r.core_en;
        end
      endcase
    end
    // upper sources see flag, enable and upper_prio_nz here; their priority lives elsewhere
    st_nxt.upper_req = upper_gate;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.en_upper <= intc_pkg::RST_EN_UPPER;
      st_r.prio_first <= intc_pkg::RST_PRIO_FIRST;
      st_r.core_en <= intc_pkg::RST_CORE_EN;
      st_r.upper_req <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // status words are built once here; the read mux only selects them
  assign pending_word = {12'h000, core_elig, 2'h0, st_r.upper_req};
  assign grant_word = {24'h000000, arb.grant_valid, arb.grant_id,
    arb.grant_prio, arb.grant_sub};

  // read mux; unlisted bits read as zero
  always_comb begin
    bus.rd_data = 32'h00000000;
    case (rd_sel)
      SEL_EN_UPPER: begin
        bus.rd_data = st_r.en_upper;
      end
      SEL_PRIO_FIRST: begin
        bus.rd_data = st_r.prio_first;
      end
      SEL_CORE_EN: begin
        bus.rd_data = {28'h0000000, st_r.core_en};
      end
      SEL_PENDING: begin
        bus.rd_data = pending_word;
      end
      SEL_GRANT: begin
        bus.rd_data = grant_word;
      end
      default: begin
        bus.rd_data = 32'h00000000;
      end
    endcase
  end

  assign upper_req = st_r.upper_req;
  assign core_grant_valid = arb.grant_valid;
  assign core_grant_id = arb.grant_id;
  assign core_grant_prio = arb.grant_prio;
  assign core_grant_sub = arb.grant_sub;
endmodule : intc_top

// [verification/intc_checker.sv]
`timescale 1ns/1ps
module intc_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [13:0] upper_flag,
  input wire logic [13:0] upper_prio_nz,
  input wire logic [13:0] upper_req,
  input wire logic core_grant_valid,
  input wire logic [2:0] core_grant_prio
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_req_flag: assert property ((upper_req & ~$past(upper_flag)) == 14'h0)
    else $error("request without flag");
  a_req_prio: assert property ((upper_req & ~$past(upper_prio_nz)) == 14'h0)
    else $error("request with zero priority");
  a_grant_prio: assert property (core_grant_valid |-> core_grant_prio != 3'h0)
    else $error("grant at priority zero");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_no_accept: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == intc_pkg::RESP_SLVERR);
  c_top_prio: cover property (core_grant_valid && core_grant_prio == 3'h7);
  c_req: cover property (upper_req != 14'h0);
endmodule : intc_checker

bind intc_top intc_checker intc_checker_i (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .upper_flag, .upper_prio_nz,
  .upper_req, .core_grant_valid, .core_grant_prio);

// [verification/intc_top_tb_top.sv]
`timescale 1ns/1ps
module intc_top_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic aw = 1'b0, w = 1'b0, bry = 1'b0, ar = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [13:0] uf = 14'h0, un = 14'h0;
  logic [3:0] cf = 4'h0;
  logic awr, wr_rdy, bv, arr, rv, gv;
  logic [1:0] br, rr, gid, gs;
  logic [31:0] rdat;
  logic [13:0] ureq;
  logic [2:0] gp;
  int mismatches = 0;
  int checks_done = 0;

  intc_top intc_top_i (.clk, .sys_rst, .s_axi_awaddr(awa), .s_axi_awvalid(aw),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(w),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .upper_flag(uf),
    .upper_prio_nz(un), .upper_req(ureq), .core_flag(cf), .core_grant_valid(gv),
    .core_grant_id(gid), .core_grant_prio(gp), .core_grant_sub(gs));

  initial forever #12.5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // readies are looked at before the edge so the race with the edge never matters
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awa <= a; wd <= d; aw <= 1'b1; w <= 1'b1;
    do begin
      @(negedge clk);
      ta = aw && awr;
      tw = w && wr_rdy;
      @(posedge clk);
      if (ta) aw <= 1'b0;
      if (tw) w <= 1'b0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    do begin @(negedge clk); ta = bv; @(posedge clk); end while (!ta);
    chk("bresp", 32'(br), 32'(er));
    bry <= 1'b1;
    @(posedge clk);
    bry <= 1'b0;
  endtask : wr

  // rready comes a cycle late on purpose so the held response is exercised
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic t;
    @(posedge clk);
    ara <= a; ar <= 1'b1;
    do begin @(negedge clk); t = arr; @(posedge clk); end while (!t);
    ar <= 1'b0;
    do begin @(negedge clk); t = rv; @(posedge clk); end while (!t);
    rry <= 1'b1;
    @(posedge clk);
    chk("rdata", rdat, e);
    chk("rresp", 32'(rr), 32'(er));
    rry <= 1'b0;
  endtask : rchk

  task automatic gchk(input logic [7:0] e);
    repeat (3) @(posedge clk);
    chk("grant", 32'({gv, gid, gp, gs}), 32'(e));
  endtask : gchk

  task automatic t_reset();
    rchk(intc_pkg::OFS_EN_UPPER, 32'h0, intc_pkg::RESP_OKAY);
    rchk(intc_pkg::OFS_PRIO_FIRST, 32'h0, intc_pkg::RESP_OKAY);
    chk("upper_req", 32'(ureq), 32'h0);
  endtask : t_reset

  task automatic t_enables();
    uf <= 14'h3fff;
    un <= 14'h3fff;
    for (int i = 0; i < 14; i++) begin
      wr(intc_pkg::OFS_EN_UPPER, 32'h1 << i, intc_pkg::RESP_OKAY);
      rchk(intc_pkg::OFS_EN_UPPER, 32'h1 << i, intc_pkg::RESP_OKAY);
      chk("upper_req", 32'(ureq), 32'h1 << i);
    end
  endtask : t_enables

  task automatic t_masking();
    wr(intc_pkg::OFS_EN_UPPER, 32'h3fff, intc_pkg::RESP_OKAY);
    uf <= 14'h2aaa;
    un <= 14'h3ff0;
    repeat (2) @(posedge clk);
    chk("upper_req", 32'(ureq), 32'h2aa0);
    rchk(intc_pkg::OFS_PENDING, 32'h00002aa0, intc_pkg::RESP_OKAY);
    wr(intc_pkg::OFS_EN_UPPER, 32'h0, intc_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("upper_req", 32'(ureq), 32'h0);
  endtask : t_masking

  task automatic t_priority();
    wr(intc_pkg::OFS_CORE_EN, 32'hf, intc_pkg::RESP_OKAY);
    cf <= 4'hf;
    wr(intc_pkg::OFS_PRIO_FIRST, 32'h1d171604, intc_pkg::RESP_OKAY);
    rchk(intc_pkg::OFS_PRIO_FIRST, 32'h1d171604, intc_pkg::RESP_OKAY);
    gchk({1'b1, 2'd3, 3'd7, 2'd1});
    rchk(intc_pkg::OFS_GRANT, 32'h000000fd, intc_pkg::RESP_OKAY);
    rchk(intc_pkg::OFS_PENDING, 32'h000f0000, intc_pkg::RESP_OKAY);
    wr(intc_pkg::OFS_PRIO_FIRST, 32'h00171604, intc_pkg::RESP_OKAY);
    gchk({1'b1, 2'd2, 3'd5, 2'd3});
    cf <= 4'h3;
    gchk({1'b1, 2'd1, 3'd5, 2'd2});
    wr(intc_pkg::OFS_PRIO_FIRST, 32'h00000004, intc_pkg::RESP_OKAY);
    gchk({1'b1, 2'd0, 3'd1, 2'd0});
    wr(intc_pkg::OFS_PRIO_FIRST, 32'h0, intc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("grant_valid", 32'(gv), 32'h0);
  endtask : t_priority

  task automatic t_unmapped();
    wr(8'h20, 32'h3fff, intc_pkg::RESP_SLVERR);
    rchk(8'h20, 32'h0, intc_pkg::RESP_SLVERR);
    rchk(intc_pkg::OFS_EN_UPPER, 32'h0, intc_pkg::RESP_OKAY);
  endtask : t_unmapped

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_enables();
    t_masking();
    t_priority();
    t_unmapped();
    stop_test();
  end
endmodule : intc_top_tb_top
